// *** rtl/motion_pkg.sv ***
// Constants, types and helpers for the two-axis settings and homing block
// Behaviour
// RULE_01 - Edits act at once; restart restores saved
// RULE_02 - Leaving edit asks: confirm saves, stop skips
// RULE_03 - After confirmation return to jog mode
// RULE_04 - Restore switch or command loads factory defaults
// RULE_05 - Four speed groups per axis, group one default
// RULE_06 - Speeds 10 to 500000 pps, defaults 500/3000
// RULE_07 - Ramp 1 to 1000 ms, default 100
// RULE_08 - Group one drives host speed; host writes groups
// RULE_09 - Group ramp also governs stops and reversals
// RULE_10 - Angle codes 0-15 select partition factors
// RULE_11 - Separate angle code per axis, default 02
// RULE_12 - Edits and homing accepted only from allowed modes
// RULE_13 - Homing only from jog or step feed
// RULE_14 - Home flagged axes; origin zeroes, prior mode back
// RULE_15 - Home failure flags error, only stop clears
// RULE_16 - Speed edit: confirm advances, high steps back
// RULE_17 - Out-of-range speed and ramp values are clamped
package motion_pkg;
	localparam logic [18:0] RATE_MIN = 19'h0000A;
	localparam logic [18:0] RATE_MAX = 19'h7A120;
	localparam logic [18:0] LOW_DEF  = 19'h001F4;
	localparam logic [18:0] HIGH_DEF = 19'h00BB8;
	localparam logic [9:0]  RAMP_MIN = 10'h001;
	localparam logic [9:0]  RAMP_MAX = 10'h3E8;
	localparam logic [9:0]  RAMP_DEF = 10'h064;
	localparam logic [3:0]  ANGLE_DEF = 4'h2;
	localparam logic [1:0]  AXG_DEF  = 2'h0;
	// Register byte offsets
	localparam logic [7:0] OFF_CMD   = 8'h00;
	localparam logic [7:0] OFF_EDIT  = 8'h04;
	localparam logic [7:0] OFF_STAT  = 8'h08;
	localparam logic [7:0] OFF_IST   = 8'h0C;
	localparam logic [7:0] OFF_IMASK = 8'h10;
	localparam logic [7:0] OFF_HSEL  = 8'h14;
	localparam logic [7:0] OFF_AXGRP = 8'h18;
	localparam logic [7:0] OFF_ANGLE = 8'h1C;
	localparam logic [7:0] OFF_GRP0  = 8'h20;
	localparam logic [7:0] OFF_GRP3E = 8'h5B;
	// Status field positions
	localparam int ST_ITEM_LSB = 12;
	localparam int ST_HRUN_LSB = 16;
	localparam int ST_FAIL_BIT = 18;
	// Interrupt bits
	localparam int IRQ_HDONE = 0;
	localparam int IRQ_HFAIL = 1;
	localparam int IRQ_SAVED = 2;
	// Command codes written to OFF_CMD
	localparam logic [7:0] CMD_SPEED   = 8'h01;
	localparam logic [7:0] CMD_ANGLE   = 8'h02;
	localparam logic [7:0] CMD_PARAM   = 8'h03;
	localparam logic [7:0] CMD_ABSMOVE = 8'h04;
	localparam logic [7:0] CMD_JS      = 8'h05;
	localparam logic [7:0] CMD_HOME    = 8'h06;
	localparam logic [7:0] CMD_ENT     = 8'h10;
	localparam logic [7:0] CMD_HIGH    = 8'h11;
	localparam logic [7:0] CMD_MENU    = 8'h12;
	localparam logic [7:0] CMD_STOP    = 8'h13;
	localparam logic [7:0] CMD_RESTART = 8'h20;
	localparam logic [7:0] CMD_RESTORE = 8'h21;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [8:0] {
		M_JOG     = 9'h001,
		M_STEP    = 9'h002,
		M_ABSMOVE = 9'h004,
		M_SPEED   = 9'h008,
		M_ANGLE   = 9'h010,
		M_PARAM   = 9'h020,
		M_CONF    = 9'h040,
		M_HOME    = 9'h080,
		M_ERR     = 9'h100
	} mode_t;

	typedef struct packed {
		logic [18:0] low;
		logic [18:0] high;
		logic [9:0]  ramp;
	} grp_t;

	typedef struct packed {
		logic [18:0] low;
		logic [18:0] high;
		logic [9:0]  ramp;
		logic [8:0]  part2;
		logic [3:0]  code;
	} axcfg_t;

	// RULE_10 partition factor table
	// Partition factor times two (2.5 becomes 5)
	function automatic logic [8:0] part2(input logic [3:0] c);
		case (c)
			4'h0: part2 = 9'h002;
			4'h1: part2 = 9'h004;
			4'h2: part2 = 9'h005;
			4'h3: part2 = 9'h008;
			4'h4: part2 = 9'h00A;
			4'h5: part2 = 9'h010;
			4'h6: part2 = 9'h014;
			4'h7: part2 = 9'h028;
			4'h8: part2 = 9'h032;
			4'h9: part2 = 9'h050;
			4'hA: part2 = 9'h064;
			4'hB: part2 = 9'h0A0;
			4'hC: part2 = 9'h0C8;
			4'hD: part2 = 9'h0FA;
			4'hE: part2 = 9'h190;
			default: part2 = 9'h1F4;
		endcase
	endfunction

	// RULE_06 RULE_17 speed clamp
	function automatic logic [18:0] clamp_rate(input logic [31:0] v);
		if (v < 32'(RATE_MIN))
			clamp_rate = RATE_MIN;
		else if (v > 32'(RATE_MAX))
			clamp_rate = RATE_MAX;
		else
			clamp_rate = v[18:0];
	endfunction

	// RULE_07 RULE_17 ramp clamp
	function automatic logic [9:0] clamp_ramp(input logic [31:0] v);
		if (v < 32'(RAMP_MIN))
			clamp_ramp = RAMP_MIN;
		else if (v > 32'(RAMP_MAX))
			clamp_ramp = RAMP_MAX;
		else
			clamp_ramp = v[9:0];
	endfunction

	typedef struct packed {
		logic             aw_rdy;
		logic             w_rdy;
		logic             aw_ok;
		logic             w_ok;
		logic             b_v;
		logic             ar_rdy;
		logic             r_v;
		logic [1:0]       b_resp;
		logic [1:0]       r_resp;
		logic [7:0]       waddr;
		logic [31:0]      wdata;
		logic [3:0]       wstrb;
		logic [31:0]      rdata;
		logic [4:0]       s1;
		logic [4:0]       s2;
		logic             rst_d;
		mode_t            mode;
		mode_t            prior;
		logic [3:0]       item;
		grp_t [3:0]       grp;
		grp_t [3:0]       grp_sv;
		logic [1:0][3:0]  step_angle_mode;
		logic [1:0][3:0]  ang_sv;
		logic [1:0][1:0]  axg;
		logic [1:0]       hsel;
		logic [1:0]       hrun;
		logic [1:0]       zero;
		logic             flash;
		logic             fail_ind;
		logic [2:0]       ist;
		logic [2:0]       imask;
		axcfg_t [1:0]     cfg;
		logic             irq;
	} st_t;
endpackage

// *** rtl/motion_settings.sv ***
// Settings store, mode control and origin return behind an AXI4-Lite slave
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module motion_settings import motion_pkg::*; #(
	parameter int ADDR_W = 8
) (
	input  wire logic              MCLK,
	input  wire logic              SRST,
	input  wire logic [ADDR_W-1:0] AWADDR,
	input  wire logic              AWVALID,
	output logic                   AWREADY,
	input  wire logic [31:0]       WDATA,
	input  wire logic [3:0]        WSTRB,
	input  wire logic              WVALID,
	output logic                   WREADY,
	output logic [1:0]             BRESP,
	output logic                   BVALID,
	input  wire logic              BREADY,
	input  wire logic [ADDR_W-1:0] ARADDR,
	input  wire logic              ARVALID,
	output logic                   ARREADY,
	output logic [31:0]            RDATA,
	output logic [1:0]             RRESP,
	output logic                   RVALID,
	input  wire logic              RREADY,
	input  wire logic [1:0]        ORIGIN_IN,
	input  wire logic [1:0]        HOME_FAIL_IN,
	input  wire logic              RESTORE_SW,
	output axcfg_t                 AXIS_A_CFG,
	output axcfg_t                 AXIS_B_CFG,
	output logic [1:0]             HOME_RUN,
	output logic [1:0]             COORD_ZERO,
	output logic                   HOME_FAIL_IND,
	output logic                   FLASH_WRITE,
	output mode_t                  MODE,
	output logic                   IRQ
);
	if (ADDR_W < 8) begin : g_chk
		$error("ADDR_W must be at least 8");
	end

	st_t         s;
	st_t         n;
	logic        wr;
	logic        cmd_v;
	logic [7:0]  cmd;
	logic        edit_v;
	logic [31:0] wd;
	logic [31:0] m;
	logic [2:0]  ev;
	logic [2:0]  clr;
	logic        restore;
	logic [1:0]  g;

	function automatic logic reg_hit(input logic [7:0] a);
		if (a[1:0] != 2'h0)
			reg_hit = 1'b0;
		else if (a >= OFF_GRP0)
			reg_hit = (a <= OFF_GRP3E) && (a[3:2] != 2'h3);
		else
			reg_hit = 1'b1;
	endfunction

	function automatic logic [31:0] reg_rd(input logic [7:0] a);
		logic [1:0] gi;
		gi = 2'(a[7:4] - 4'h2);
		reg_rd = '0;
		if (a >= OFF_GRP0) begin
			case (a[3:2])
				2'h0: reg_rd = 32'(s.grp[gi].low);
				2'h1: reg_rd = 32'(s.grp[gi].high);
				2'h2: reg_rd = 32'(s.grp[gi].ramp);
				default: reg_rd = '0;
			endcase
		end else begin
			case (a)
				OFF_STAT: begin
					reg_rd[8:0] = s.mode;
					reg_rd[ST_ITEM_LSB +: 4] = s.item;
					reg_rd[ST_HRUN_LSB +: 2] = s.hrun;
					reg_rd[ST_FAIL_BIT] = s.fail_ind;
				end
				OFF_IST:   reg_rd = 32'(s.ist);
				OFF_IMASK: reg_rd = 32'(s.imask);
				OFF_HSEL:  reg_rd = 32'(s.hsel);
				OFF_AXGRP: reg_rd = 32'(s.axg);
				OFF_ANGLE: reg_rd = 32'(s.step_angle_mode);
				default:   reg_rd = '0;
			endcase
		end
	endfunction

	always_comb begin
		n = s;
		n.flash = 1'b0;
		n.zero = '0;
		ev = '0;
		clr = '0;
		n.s1 = {RESTORE_SW, HOME_FAIL_IN, ORIGIN_IN};
		n.s2 = s.s1;
		n.rst_d = s.s2[4];
		// Read channel
		if (s.r_v && RREADY)
			n.r_v = 1'b0;
		if (ARVALID && s.ar_rdy) begin
			n.r_v = 1'b1;
			n.rdata = reg_rd(ARADDR[7:0]);
			n.r_resp = reg_hit(ARADDR[7:0]) ? RESP_OKAY : RESP_SLVERR;
		end
		n.ar_rdy = !n.r_v;
		// Write channel: address and data in either order
		m = {{8{s.wstrb[3]}}, {8{s.wstrb[2]}},
			{8{s.wstrb[1]}}, {8{s.wstrb[0]}}};
		wd = (reg_rd(s.waddr) & ~m) | (s.wdata & m);
		wr = s.aw_ok && s.w_ok && !s.b_v;
		if (s.b_v && BREADY)
			n.b_v = 1'b0;
		if (wr) begin
			n.aw_ok = 1'b0;
			n.w_ok = 1'b0;
			n.b_v = 1'b1;
			n.b_resp = reg_hit(s.waddr) ? RESP_OKAY : RESP_SLVERR;
		end
		if (AWVALID && s.aw_rdy) begin
			n.aw_ok = 1'b1;
			n.waddr = AWADDR[7:0];
		end
		if (WVALID && s.w_rdy) begin
			n.w_ok = 1'b1;
			n.wdata = WDATA;
			n.wstrb = WSTRB;
		end
		n.aw_rdy = !n.aw_ok && !n.b_v;
		n.w_rdy = !n.w_ok && !n.b_v;
		cmd_v = wr && s.waddr == OFF_CMD && s.wstrb[0];
		cmd = s.wdata[7:0];
		edit_v = wr && s.waddr == OFF_EDIT;
		g = 2'(s.waddr[7:4] - 4'h2);
		// RULE_15 error lockout
		if (wr && s.mode != M_ERR) begin
			if (s.waddr == OFF_IST)
				clr = wd[2:0];
			if (s.waddr == OFF_IMASK)
				n.imask = wd[2:0];
			if (s.waddr == OFF_HSEL)
				n.hsel = wd[1:0];
			if (s.waddr == OFF_AXGRP)
				n.axg = wd[3:0];
			// RULE_08 host group writes
			if (reg_hit(s.waddr) && s.waddr >= OFF_GRP0) begin
				// RULE_17 range clamp
				case (s.waddr[3:2])
					2'h0: n.grp[g].low = clamp_rate(wd);
					2'h1: n.grp[g].high = clamp_rate(wd);
					default: n.grp[g].ramp = clamp_ramp(wd);
				endcase
			end
		end
		// RULE_01 restart reloads saved values
		if (cmd_v && cmd == CMD_RESTART && s.mode != M_ERR) begin
			n.grp = s.grp_sv;
			n.step_angle_mode = s.ang_sv;
		end
		unique case (s.mode)
			// RULE_12 mode entry gating
			M_JOG, M_STEP, M_ABSMOVE: if (cmd_v) begin
				if (cmd == CMD_SPEED || cmd == CMD_PARAM) begin
					n.mode = (cmd == CMD_SPEED) ? M_SPEED : M_PARAM;
					n.item = '0;
				end else if (cmd == CMD_ANGLE && s.mode == M_JOG) begin
					n.mode = M_ANGLE;
					n.item = '0;
				end else if (cmd == CMD_JS && s.mode != M_ABSMOVE) begin
					n.mode = (s.mode == M_JOG) ? M_STEP : M_JOG;
				end else if (cmd == CMD_ABSMOVE && s.mode != M_ABSMOVE) begin
					n.mode = M_ABSMOVE;
				end else if (cmd == CMD_STOP && s.mode == M_ABSMOVE) begin
					n.mode = M_JOG;
				end else if (cmd == CMD_HOME && s.mode != M_ABSMOVE) begin
					// RULE_13 homing from jog or step only
					n.mode = M_HOME;
					n.prior = s.mode;
					n.hrun = s.hsel;
				end
			end
			M_SPEED: begin
				// RULE_01 edit takes effect at once
				if (edit_v) begin
					case (s.item[1:0])
						2'h0: n.grp[s.item[3:2]].low = clamp_rate(wd);
						2'h1: n.grp[s.item[3:2]].high = clamp_rate(wd);
						default: n.grp[s.item[3:2]].ramp = clamp_ramp(wd);
					endcase
				end
				// RULE_16 item walk
				if (cmd_v && cmd == CMD_ENT)
					n.item = (s.item[1:0] == 2'h2) ?
						{s.item[3:2] + 2'h1, 2'h0} : s.item + 4'h1;
				else if (cmd_v && cmd == CMD_HIGH)
					n.item = (s.item[1:0] == 2'h0) ?
						{s.item[3:2] - 2'h1, 2'h2} : s.item - 4'h1;
				else if (cmd_v && cmd == CMD_MENU)
					n.mode = M_CONF;
			end
			M_ANGLE: begin
				if (edit_v)
					n.step_angle_mode[s.item[0]] = wd[3:0];
				if (cmd_v && cmd == CMD_ENT)
					n.item = {3'h0, ~s.item[0]};
				else if (cmd_v && cmd == CMD_MENU)
					n.mode = M_CONF;
			end
			M_PARAM: if (cmd_v && cmd == CMD_MENU)
				n.mode = M_CONF;
			M_CONF: if (cmd_v) begin
				// RULE_02 confirm saves, stop keeps temporary
				if (cmd == CMD_ENT) begin
					n.grp_sv = s.grp;
					n.ang_sv = s.step_angle_mode;
					n.flash = 1'b1;
					ev[IRQ_SAVED] = 1'b1;
				end
				// RULE_03 back to jog
				if (cmd == CMD_ENT || cmd == CMD_STOP)
					n.mode = M_JOG;
			end
			M_HOME: begin
				// RULE_14 per-axis origin stop and zero
				n.zero = s.hrun & s.s2[1:0];
				n.hrun = s.hrun & ~s.s2[1:0];
				if (|(s.hrun & s.s2[3:2])) begin
					n.mode = M_ERR;
					n.hrun = '0;
					n.fail_ind = 1'b1;
					ev[IRQ_HFAIL] = 1'b1;
				end else if (cmd_v && cmd == CMD_STOP) begin
					n.mode = s.prior;
					n.hrun = '0;
				end else if (n.hrun == '0) begin
					n.mode = s.prior;
					ev[IRQ_HDONE] = 1'b1;
				end
			end
			M_ERR: if (cmd_v && cmd == CMD_STOP) begin
				// RULE_15 stop clears the error
				n.mode = s.prior;
				n.fail_ind = 1'b0;
			end
			default: n.mode = M_JOG;
		endcase
		// RULE_04 factory defaults
		// Switch and command alike are locked out by a home failure
		restore = ((s.s2[4] && !s.rst_d) ||
			(cmd_v && cmd == CMD_RESTORE)) && s.mode != M_ERR;
		if (restore) begin
			for (int i = 0; i < 4; i++) begin
				n.grp[i] = '{LOW_DEF, HIGH_DEF, RAMP_DEF};
				n.grp_sv[i] = '{LOW_DEF, HIGH_DEF, RAMP_DEF};
			end
			n.step_angle_mode = {ANGLE_DEF, ANGLE_DEF};
			n.ang_sv = {ANGLE_DEF, ANGLE_DEF};
			n.flash = 1'b1;
		end
		n.ist = (s.ist & ~clr) | ev;
		n.irq = |(n.ist & n.imask);
		// RULE_09 group ramp feeds every stop and reversal
		for (int i = 0; i < 2; i++)
			n.cfg[i] = {n.grp[n.axg[i]], part2(n.step_angle_mode[i]), n.step_angle_mode[i]};
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			s <= '0;
			s.mode <= M_JOG;
			s.prior <= M_JOG;
			// RULE_05 group defaults
			for (int i = 0; i < 4; i++) begin
				s.grp[i] <= '{LOW_DEF, HIGH_DEF, RAMP_DEF};
				s.grp_sv[i] <= '{LOW_DEF, HIGH_DEF, RAMP_DEF};
			end
			// RULE_11 per-axis angle default
			s.step_angle_mode <= {ANGLE_DEF, ANGLE_DEF};
			s.ang_sv <= {ANGLE_DEF, ANGLE_DEF};
			s.axg <= {AXG_DEF, AXG_DEF};
			for (int i = 0; i < 2; i++)
				s.cfg[i] <= {LOW_DEF, HIGH_DEF, RAMP_DEF,
					part2(ANGLE_DEF), ANGLE_DEF};
		end else begin
			s <= n;
		end
	end

	assign AWREADY = s.aw_rdy;
	assign WREADY = s.w_rdy;
	assign BVALID = s.b_v;
	assign BRESP = s.b_resp;
	assign ARREADY = s.ar_rdy;
	assign RVALID = s.r_v;
	assign RDATA = s.rdata;
	assign RRESP = s.r_resp;
	assign AXIS_A_CFG = s.cfg[0];
	assign AXIS_B_CFG = s.cfg[1];
	assign HOME_RUN = s.hrun;
	assign COORD_ZERO = s.zero;
	assign HOME_FAIL_IND = s.fail_ind;
	assign FLASH_WRITE = s.flash;
	assign MODE = s.mode;
	assign IRQ = s.irq;

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SRST);

	property p_rate_range;
		s.grp[0].low >= RATE_MIN && s.grp[0].low <= RATE_MAX &&
		s.grp[3].high >= RATE_MIN && s.grp[3].high <= RATE_MAX;
	endproperty
	a_rate_range: assert property (p_rate_range) else $error("speeds"); // RULE_06
	property p_ramp_range;
		s.grp[1].ramp >= RAMP_MIN && s.grp[1].ramp <= RAMP_MAX;
	endproperty
	a_ramp_range: assert property (p_ramp_range) else $error("ramp range"); // RULE_07
	property p_save;
		cmd_v && cmd == CMD_ENT && s.mode == M_CONF |=>
			FLASH_WRITE && s.grp_sv == $past(s.grp) && MODE == M_JOG;
	endproperty
	a_save: assert property (p_save) else $error("confirm save"); // RULE_02
	property p_skip;
		cmd_v && cmd == CMD_STOP && s.mode == M_CONF |=>
			!FLASH_WRITE && MODE == M_JOG;
	endproperty
	a_skip: assert property (p_skip) else $error("confirm skip"); // RULE_03
	property p_home_entry;
		$rose(MODE == M_HOME) |-> $past(MODE) inside {M_JOG, M_STEP};
	endproperty
	a_home_entry: assert property (p_home_entry) else $error("home entry"); // RULE_13
	sequence s_origin;
		MODE == M_HOME && s.hrun[0] && s.s2[0] && !(|s.s2[3:2]);
	endsequence
	sequence s_zeroed;
		COORD_ZERO[0] && !HOME_RUN[0];
	endsequence
	property p_origin;
		s_origin |=> s_zeroed;
	endproperty
	a_origin: assert property (p_origin) else $error("origin stop"); // RULE_14
	property p_err_hold;
		MODE == M_ERR && !(cmd_v && cmd == CMD_STOP) |=>
			MODE == M_ERR && HOME_FAIL_IND && $stable(s.grp);
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error lockout"); // RULE_15
	property p_restart;
		cmd_v && cmd == CMD_RESTART && MODE != M_ERR |=>
			s.grp == $past(s.grp_sv) && s.step_angle_mode == $past(s.ang_sv);
	endproperty
	a_restart: assert property (p_restart) else $error("restart"); // RULE_01
	property p_restore;
		cmd_v && cmd == CMD_RESTORE && MODE != M_ERR |=>
			s.grp[2].low == LOW_DEF && s.step_angle_mode[1] == ANGLE_DEF ##1
			AXIS_B_CFG.code == ANGLE_DEF;
	endproperty
	a_restore: assert property (p_restore) else $error("restore"); // RULE_04
	property p_ent_adv;
		cmd_v && cmd == CMD_ENT && MODE == M_SPEED && s.item == 4'h0 |=>
			s.item == 4'h1;
	endproperty
	a_ent_adv: assert property (p_ent_adv) else $error("item advance"); // RULE_16
	property p_angle_gate;
		cmd_v && cmd == CMD_ANGLE && MODE != M_JOG |=> MODE != M_ANGLE;
	endproperty
	a_angle_gate: assert property (p_angle_gate) else $error("angle"); // RULE_12
endmodule

// *** verif/stage_model.sv ***
// Behavioural model of the two stepper stages answering an origin return
`timescale 1ns/1ps
module stage_model (
	input  wire logic       MCLK,
	input  wire logic       SRST,
	input  wire logic [1:0] home_run,
	input  wire logic       fail_on,
	input  wire logic [7:0] dly,
	output logic [1:0]      origin,
	output logic [1:0]      failed
);
	logic [7:0] cnt [2];

	initial begin
		origin = 2'h0;
		failed = 2'h0;
	end

	// Axis B travels longer so the two axes finish apart
	always @(posedge MCLK) begin
		for (int i = 0; i < 2; i++) begin
			if (SRST || home_run[i] !== 1'b1) begin
				cnt[i] <= 8'h00;
				origin[i] <= 1'b0;
				failed[i] <= 1'b0;
			end else if (cnt[i] < dly + (i == 1 ? 8'h08 : 8'h00)) begin
				cnt[i] <= cnt[i] + 8'h01;
			end else begin
				origin[i] <= !fail_on;
				failed[i] <= fail_on;
			end
		end
	end
endmodule

// *** verif/test_two_axis_motion_settings_homing.sv ***
// Self-checking bench for the settings and origin return block
`timescale 1ns/1ps
module test_two_axis_motion_settings_homing import motion_pkg::*;;
	localparam axcfg_t CFG_DEF = {LOW_DEF, HIGH_DEF, RAMP_DEF, 9'h005,
		ANGLE_DEF};
	logic        MCLK = 1'b0;
	logic        SRST = 1'b1;
	logic [7:0]  AWADDR = 8'h00;
	logic        AWVALID = 1'b0;
	logic [31:0] WDATA = 32'h0;
	logic [3:0]  WSTRB = 4'hF;
	logic        WVALID = 1'b0;
	logic        BREADY = 1'b0;
	logic [7:0]  ARADDR = 8'h00;
	logic        ARVALID = 1'b0;
	logic        RREADY = 1'b0;
	logic        RESTORE_SW = 1'b0;
	logic        fail_on = 1'b0;
	logic [7:0]  dly = 8'h10;
	logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic        HOME_FAIL_IND, FLASH_WRITE, IRQ;
	logic [1:0]  BRESP, RRESP, HOME_RUN, COORD_ZERO, ORIGIN_IN, HOME_FAIL_IN;
	logic [31:0] RDATA;
	logic [31:0] rd;
	logic [1:0]  rs;
	axcfg_t      AXIS_A_CFG, AXIS_B_CFG;
	mode_t       MODE;
	int          bad_count = 0;
	int          checked = 0;
	int          flashes = 0;
	int          zeros = 0;
	logic [8:0]  pf2 [16] = '{9'h002, 9'h004, 9'h005, 9'h008, 9'h00A, 9'h010,
		9'h014, 9'h028, 9'h032, 9'h050, 9'h064, 9'h0A0, 9'h0C8, 9'h0FA,
		9'h190, 9'h1F4};

	always #10 MCLK = ~MCLK;

	always @(posedge MCLK) begin
		flashes += int'(FLASH_WRITE === 1'b1);
		zeros += int'(COORD_ZERO[0] === 1'b1) + int'(COORD_ZERO[1] === 1'b1);
	end

	motion_settings #(.ADDR_W(8)) dut_u (.MCLK, .SRST, .AWADDR, .AWVALID,
		.AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
		.ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
		.ORIGIN_IN, .HOME_FAIL_IN, .RESTORE_SW, .AXIS_A_CFG, .AXIS_B_CFG,
		.HOME_RUN, .COORD_ZERO, .HOME_FAIL_IND, .FLASH_WRITE, .MODE, .IRQ);

	stage_model stage_u (.MCLK, .SRST, .home_run(HOME_RUN), .fail_on, .dly,
		.origin(ORIGIN_IN), .failed(HOME_FAIL_IN));

	task automatic chk(input logic [63:0] g, input logic [63:0] e,
			input string m);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge MCLK);
	endtask

	// Address and data are offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge MCLK);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		do begin
			@(posedge MCLK);
			if (AWVALID && AWREADY === 1'b1)
				AWVALID <= 1'b0;
			if (WVALID && WREADY === 1'b1)
				WVALID <= 1'b0;
		end while (BVALID !== 1'b1);
		rs = BRESP;
		BREADY <= 1'b0;
	endtask

	task automatic rdr(input logic [7:0] a);
		@(posedge MCLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do begin
			@(posedge MCLK);
			if (ARVALID && ARREADY === 1'b1)
				ARVALID <= 1'b0;
		end while (RVALID !== 1'b1);
		rd = RDATA;
		rs = RRESP;
		RREADY <= 1'b0;
	endtask

	task automatic cmd(input logic [7:0] c);
		wr(OFF_CMD, {24'h0, c});
		idle(2);
	endtask

	task automatic chk_mode(input mode_t m);
		chk(64'(MODE), 64'(m), "mode");
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
		rdr(a);
		chk(64'(rd), 64'(e), "read value");
	endtask

	task automatic t_defaults;
		chk_mode(M_JOG);
		for (int g = 0; g < 4; g++) begin
			chk_rd(OFF_GRP0 + 8'(g * 16), 32'h1F4);
			chk_rd(OFF_GRP0 + 8'(g * 16 + 4), 32'hBB8);
			chk_rd(OFF_GRP0 + 8'(g * 16 + 8), 32'h64);
		end
		chk_rd(OFF_ANGLE, 32'h22);
		chk_rd(OFF_AXGRP, 32'h0);
		chk(64'(AXIS_B_CFG), 64'(CFG_DEF), "cfg default");
		rdr(8'h60);
		chk(64'(rs), 64'(RESP_SLVERR), "unmapped read");
		wr(8'h60, 32'h1);
		chk(64'(rs), 64'(RESP_SLVERR), "unmapped write");
	endtask

	task automatic t_host;
		wr(OFF_GRP0 + 8'h10, 32'h5);
		chk_rd(OFF_GRP0 + 8'h10, 32'hA);
		wr(OFF_GRP0 + 8'h14, 32'h927C0);
		chk_rd(OFF_GRP0 + 8'h14, 32'h7A120);
		wr(OFF_GRP0 + 8'h18, 32'h0);
		wr(OFF_GRP0 + 8'h38, 32'h7D0);
		wr(OFF_AXGRP, 32'hD);
		idle(2);
		chk(64'(AXIS_A_CFG.low), 64'h0A, "group low");
		chk(64'(AXIS_A_CFG.ramp), 64'h1, "ramp floor");
		chk(64'(AXIS_B_CFG.ramp), 64'h3E8, "ramp ceiling");
		wr(OFF_AXGRP, 32'h0);
	endtask

	task automatic t_angle;
		int f0;
		f0 = flashes;
		cmd(CMD_ANGLE);
		chk_mode(M_ANGLE);
		for (int c = 0; c < 16; c++) begin
			wr(OFF_EDIT, 32'(c));
			idle(2);
			chk(64'(AXIS_A_CFG.part2), 64'(pf2[c]), "factor");
		end
		cmd(CMD_ENT);
		wr(OFF_EDIT, 32'h9);
		chk_rd(OFF_ANGLE, 32'h9F);
		cmd(CMD_MENU);
		chk_mode(M_CONF);
		cmd(CMD_STOP);
		chk_mode(M_JOG);
		chk(64'(flashes - f0), 64'h0, "no save");
		cmd(CMD_RESTART);
		chk_rd(OFF_ANGLE, 32'h22);
		cmd(CMD_ANGLE);
		wr(OFF_EDIT, 32'h7);
		cmd(CMD_MENU);
		cmd(CMD_ENT);
		chk_mode(M_JOG);
		chk(64'(flashes - f0), 64'h1, "saved");
		rdr(OFF_IST);
		chk(64'(rd[IRQ_SAVED]), 64'h1, "saved event");
		cmd(CMD_RESTART);
		chk_rd(OFF_ANGLE, 32'h27);
		wr(OFF_IST, 32'h7);
	endtask

	task automatic t_speed;
		cmd(CMD_PARAM);
		chk_mode(M_PARAM);
		cmd(CMD_MENU);
		chk_mode(M_CONF);
		cmd(CMD_STOP);
		chk_mode(M_JOG);
		cmd(CMD_JS);
		chk_mode(M_STEP);
		cmd(CMD_ANGLE);
		chk_mode(M_STEP);
		cmd(CMD_SPEED);
		chk_mode(M_SPEED);
		wr(OFF_EDIT, 32'h3039);
		idle(2);
		chk(64'(AXIS_A_CFG.low), 64'h3039, "applied at once");
		cmd(CMD_ENT);
		cmd(CMD_ENT);
		chk_rd(OFF_STAT, 32'(M_SPEED) | 32'h2000);
		cmd(CMD_HIGH);
		chk_rd(OFF_STAT, 32'(M_SPEED) | 32'h1000);
		wr(OFF_EDIT, 32'h0);
		chk_rd(OFF_GRP0 + 8'h04, 32'hA);
		cmd(CMD_MENU);
		cmd(CMD_STOP);
		chk_mode(M_JOG);
	endtask

	task automatic t_home;
		int z0;
		cmd(CMD_ABSMOVE);
		chk_mode(M_ABSMOVE);
		cmd(CMD_HOME);
		chk_mode(M_ABSMOVE);
		cmd(CMD_STOP);
		chk_mode(M_JOG);
		wr(OFF_IMASK, 32'h1);
		wr(OFF_HSEL, 32'h2);
		cmd(CMD_JS);
		z0 = zeros;
		cmd(CMD_HOME);
		chk_mode(M_HOME);
		chk(64'(HOME_RUN), 64'h2, "flagged axis only");
		while (MODE !== M_STEP)
			@(posedge MCLK);
		// Let the pulse counter take the edge the loop stopped on
		idle(1);
		chk(64'(zeros - z0), 64'h1, "origin zeroed");
		rdr(OFF_IST);
		chk(64'({rd[IRQ_HDONE], IRQ}), 64'h3, "home done");
		wr(OFF_IST, 32'h1);
		rdr(OFF_IST);
		chk(64'({rd[IRQ_HDONE], IRQ}), 64'h0, "cleared");
		cmd(CMD_JS);
		wr(OFF_HSEL, 32'h3);
		cmd(CMD_HOME);
		chk(64'(HOME_RUN), 64'h3, "both axes");
		while (MODE !== M_JOG)
			@(posedge MCLK);
		idle(1);
		chk(64'(zeros - z0), 64'h3, "both zeroed");
		wr(OFF_IST, 32'h1);
	endtask

	task automatic t_fail;
		fail_on <= 1'b1;
		wr(OFF_IMASK, 32'h2);
		wr(OFF_HSEL, 32'h1);
		cmd(CMD_HOME);
		while (MODE !== M_ERR)
			@(posedge MCLK);
		chk(64'(HOME_FAIL_IND), 64'h1, "failure shown");
		rdr(OFF_STAT);
		chk(64'({rd[ST_FAIL_BIT], IRQ}), 64'h3, "failure flag");
		cmd(CMD_SPEED);
		chk_mode(M_ERR);
		fail_on <= 1'b0;
		cmd(CMD_STOP);
		chk_mode(M_JOG);
		chk(64'(HOME_FAIL_IND), 64'h0, "failure cleared");
		wr(OFF_IST, 32'h2);
		cmd(CMD_HOME);
		chk_mode(M_HOME);
		cmd(CMD_STOP);
		chk_mode(M_JOG);
		chk(64'(HOME_RUN), 64'h0, "home aborted");
	endtask

	task automatic t_restore;
		int f0;
		f0 = flashes;
		wr(OFF_GRP0 + 8'h28, 32'h3E8);
		cmd(CMD_RESTORE);
		chk_rd(OFF_GRP0 + 8'h28, 32'h64);
		chk_rd(OFF_GRP0 + 8'h10, 32'h1F4);
		chk_rd(OFF_ANGLE, 32'h22);
		wr(OFF_GRP0 + 8'h08, 32'h5);
		RESTORE_SW <= 1'b1;
		idle(4);
		RESTORE_SW <= 1'b0;
		idle(4);
		chk_rd(OFF_GRP0 + 8'h08, 32'h64);
		chk(64'(flashes - f0), 64'h2, "restore saves");
	endtask

	task automatic summarize;
		if (bad_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge MCLK);
		SRST <= 1'b0;
		idle(2);
		t_defaults();
		t_host();
		t_angle();
		t_speed();
		t_home();
		t_fail();
		t_restore();
		summarize();
	end

	// About 50000 cycles, far beyond the several hundred the tests need
	initial begin
		#1000000;
		bad_count++;
		summarize();
	end
endmodule
